// ===== pkg/tcu_pkg.sv
/*
 Constants for the three-counter timer unit: register offsets, field positions,
 reset values and timing counts. Assumes one 100 MHz clock feeds the whole unit.
*/
// Functional notes
// - Overflow flags of counters 1 and 0 set on rollover, cleared on vector.
// - Run bits 6 and 4 turn counters 1 and 0 on or off.
// - External flags set on detected interrupt; edge mode clears on processing.
// - Type bit zero selects low level, one selects falling edge.
// - Gating set lets counter run only while its interrupt pin is high.
// - Source select zero counts divided clock, one counts pin falling edges.
// - Mode field: 13-bit, 16-bit, 8-bit reload; counter 1 mode 3 halts.
// - Counter 0 mode 3 splits into two 8-bit timers, high uses counter 1 bits.
// - Auto-reload mode reloads low byte from high byte on overflow.
// - Control, mode and count bytes of counters 0 and 1 reset to zero.
// - Counter 2 is 16-bit, counts clock/6 or pin while run bit set.
// - Down-count enable makes counter 2 up/down, direction from pin.
// - Counting up, overflow at FFFFh sets flag and loads reload value.
// - Counting down, match with reload sets flag and loads FFFFh.
// - External flag toggles on each over/underflow without interrupt; code toggles it only with down-count enable set and clock-out off.
// - Clock-out mode reloads on overflow, gives 50% clock, no interrupt.
// - Clock-out rate is clock over 4 times (65536 minus reload), on pin.
// - Timer operation increments once per six clocks.
// - Counter operation samples pin per peripheral cycle, counts high-then-low.
// - 13-bit mode uses low five bits as divide-by-32 prescaler.
package tcu_pkg;
    localparam logic [7:0] ADDR_CONTROL  = 8'h88;
    localparam logic [7:0] ADDR_MODE     = 8'h89;
    localparam logic [7:0] ADDR_C0_LOW   = 8'h8A;
    localparam logic [7:0] ADDR_C1_LOW   = 8'h8B;
    localparam logic [7:0] ADDR_C0_HIGH  = 8'h8C;
    localparam logic [7:0] ADDR_C1_HIGH  = 8'h8D;
    localparam logic [7:0] ADDR_C2_CTRL  = 8'hC8;
    localparam logic [7:0] ADDR_C2_MODE  = 8'hC9;
    localparam logic [7:0] ADDR_C2_RLOW  = 8'hCA;
    localparam logic [7:0] ADDR_C2_RHIGH = 8'hCB;
    localparam logic [7:0] ADDR_C2_LOW   = 8'hCC;
    localparam logic [7:0] ADDR_C2_HIGH  = 8'hCD;
    // Control register fields.
    localparam int BIT_OVF_C1 = 7;
    localparam int BIT_RUN_C1 = 6;
    localparam int BIT_OVF_C0 = 5;
    localparam int BIT_RUN_C0 = 4;
    localparam int BIT_EXT1   = 3;
    localparam int BIT_TYPE1  = 2;
    localparam int BIT_EXT0   = 1;
    localparam int BIT_TYPE0  = 0;
    // Mode register fields, counter 1 in the upper nibble.
    localparam int BIT_GATE_C1 = 7;
    localparam int BIT_SRC_C1  = 6;
    localparam int BIT_MODE_C1 = 4;
    localparam int BIT_GATE_C0 = 3;
    localparam int BIT_SRC_C0  = 2;
    localparam int BIT_MODE_C0 = 0;
    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;
    // Counter 2 control and mode fields.
    localparam int BIT_OVF_C2  = 7;
    localparam int BIT_EXTF_C2 = 6;
    localparam int BIT_RUN_C2  = 2;
    localparam int BIT_SRC_C2  = 1;
    localparam int BIT_CKO_EN  = 1;
    localparam int BIT_DOWN_COUNT_ENABLE    = 0;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
    localparam logic [4:0]  PRESC_MAX  = 5'h1F;
    // Timing: one peripheral cycle is six clock periods.
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PER_CYCLE_NS    = 60;
    localparam int PER_CYCLE_CLKS  = (PER_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CKO_DIV_CLKS    = 2;
endpackage

// ===== hdl/three_timer_counter_unit.sv
/*
 Three counter timer unit with its register file on a plain strobe port.
 Assumes pins are asynchronous to I_CLK_SYS and that the interrupt
 controller pulses the acknowledge inputs when it vectors.
*/
`timescale 1ns/1ps
module three_timer_counter_unit (
    // Clock, reset, enable
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RESET,
    input  wire logic       i_CE,
    // Register port
    input  wire logic [7:0] i_ADDR,
    input  wire logic [7:0] i_WDATA,
    input  wire logic       i_WR,
    input  wire logic       i_RD,
    output logic      [7:0] o_RDATA,
    // Interrupt vector acknowledges
    input  wire logic       i_ACK_C0,
    input  wire logic       i_ACK_C1,
    input  wire logic       i_ACK_EXT0,
    input  wire logic       i_ACK_EXT1,
    // Pins
    input  wire logic       i_COUNTER0_EXT_PIN,
    input  wire logic       i_COUNTER1_EXT_PIN,
    input  wire logic       i_EXT_IRQ_PIN_0,
    input  wire logic       i_EXT_IRQ_PIN_1,
    input  wire logic       i_COUNTER2_EXT_PIN,
    input  wire logic       i_DIRECTION_INPUT_PIN,
    output logic            o_COUNTER2_EXT_PIN,
    output logic            o_COUNTER2_EXT_PIN_OE_N,
    // Flags toward the interrupt controller
    output logic            o_OVF_FLAG_C0,
    output logic            o_OVF_FLAG_C1,
    output logic            o_EXT_IRQ_FLAG_0,
    output logic            o_EXT_IRQ_FLAG_1,
    output logic            o_OVF_FLAG_C2
);
    import tcu_pkg::*;

    logic [7:0]  timer_control_q, timer_mode_q;
    logic [7:0]  c0_low_q, c0_high_q, c1_low_q, c1_high_q;
    logic [7:0]  c2_ctrl_q, c2_mode_q;
    logic [15:0] c2_count_q, c2_reload_q;
    logic [5:0]  s1_q, s2_q, s3_q;
    logic [2:0]  per_cnt_q;
    logic        per_tick;
    logic        cko_q;
    logic        cko_div_q;

    // Pin synchronisers: bit order t0, t1, ext_irq_pin_0, ext_irq_pin_1, t2, dir.
    logic [5:0] pins;
    assign pins = {i_DIRECTION_INPUT_PIN, i_COUNTER2_EXT_PIN, i_EXT_IRQ_PIN_1,
                   i_EXT_IRQ_PIN_0, i_COUNTER1_EXT_PIN, i_COUNTER0_EXT_PIN};
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            s1_q <= 6'h3F;
            s2_q <= 6'h3F;
            s3_q <= 6'h3F;
        end else if (i_CE) begin
            s1_q <= pins;
            s2_q <= s1_q;
            if (per_tick) begin
                s3_q <= s2_q;
            end
        end
    end

    // Peripheral cycle divider.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            per_cnt_q <= 3'h0;
        end else if (i_CE) begin
            per_cnt_q <= per_tick ? 3'h0 : per_cnt_q + 3'h1;
        end
    end
    assign per_tick = (per_cnt_q == 3'(PER_CYCLE_CLKS - 1));

    // Falling edge of a sampled pin, seen once per peripheral cycle.
    logic [5:0] fall;
    assign fall = {6{per_tick}} & s3_q & ~s2_q;

    logic [1:0] mode_c0, mode_c1;
    logic       run_c0, run_c1, inc_c0, inc_c1, inc_h0;
    assign mode_c0 = timer_mode_q[BIT_MODE_C0 +: 2];
    assign mode_c1 = timer_mode_q[BIT_MODE_C1 +: 2];
    assign run_c0 = timer_control_q[BIT_RUN_C0] &
                    (~timer_mode_q[BIT_GATE_C0] | s2_q[2]);
    assign run_c1 = timer_control_q[BIT_RUN_C1] &
                    (~timer_mode_q[BIT_GATE_C1] | s2_q[3]);
    assign inc_c0 = run_c0 & (timer_mode_q[BIT_SRC_C0] ? fall[0] : per_tick);
    assign inc_c1 = run_c1 & (timer_mode_q[BIT_SRC_C1] ? fall[1] : per_tick) &
                    (mode_c1 != MODE_SPLIT);
    // Split high byte is locked to timer source and counter 1 run bit.
    assign inc_h0 = (mode_c0 == MODE_SPLIT) & timer_control_q[BIT_RUN_C1] & per_tick;

    // Register write decode.
    logic wr_ctl, wr_mod, wr_l0, wr_h0, wr_l1, wr_h1;
    logic wr_c2c, wr_c2m, wr_rl, wr_rh, wr_l2, wr_h2;
    assign wr_ctl = i_CE & i_WR & (i_ADDR == ADDR_CONTROL);
    assign wr_mod = i_CE & i_WR & (i_ADDR == ADDR_MODE);
    assign wr_l0  = i_CE & i_WR & (i_ADDR == ADDR_C0_LOW);
    assign wr_h0  = i_CE & i_WR & (i_ADDR == ADDR_C0_HIGH);
    assign wr_l1  = i_CE & i_WR & (i_ADDR == ADDR_C1_LOW);
    assign wr_h1  = i_CE & i_WR & (i_ADDR == ADDR_C1_HIGH);
    assign wr_c2c = i_CE & i_WR & (i_ADDR == ADDR_C2_CTRL);
    assign wr_c2m = i_CE & i_WR & (i_ADDR == ADDR_C2_MODE);
    assign wr_rl  = i_CE & i_WR & (i_ADDR == ADDR_C2_RLOW);
    assign wr_rh  = i_CE & i_WR & (i_ADDR == ADDR_C2_RHIGH);
    assign wr_l2  = i_CE & i_WR & (i_ADDR == ADDR_C2_LOW);
    assign wr_h2  = i_CE & i_WR & (i_ADDR == ADDR_C2_HIGH);

    // Counters 0 and 1 share one datapath built by a generate loop.
    logic [7:0] low_q  [2];
    logic [7:0] high_q [2];
    logic [1:0] ovf;
    logic       h0_ovf;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ctr
            logic [1:0] m;
            logic       inc, wl, wh;
            logic [7:0] low_d, high_d;
            logic       ov;
            assign m   = (g == 0) ? mode_c0 : mode_c1;
            assign inc = (g == 0) ? inc_c0 : inc_c1;
            assign wl  = (g == 0) ? wr_l0 : wr_l1;
            assign wh  = (g == 0) ? wr_h0 : wr_h1;
            always_comb begin
                low_d  = low_q[g];
                high_d = high_q[g];
                ov     = 1'b0;
                if (inc) begin
                    case (m)
                        MODE_13BIT: begin
                            low_d[4:0] = low_q[g][4:0] + 5'h1;
                            if (low_q[g][4:0] == PRESC_MAX) begin
                                high_d = high_q[g] + 8'h1;
                                ov     = (high_q[g] == 8'hFF);
                            end
                        end
                        MODE_16BIT: begin
                            low_d = low_q[g] + 8'h1;
                            if (low_q[g] == 8'hFF) begin
                                high_d = high_q[g] + 8'h1;
                                ov     = (high_q[g] == 8'hFF);
                            end
                        end
                        MODE_RELOAD: begin
                            low_d = (low_q[g] == 8'hFF) ? high_q[g] : low_q[g] + 8'h1;
                            ov    = (low_q[g] == 8'hFF);
                        end
                        default: begin
                            // Split mode low byte; counter 1 never gets here.
                            low_d = low_q[g] + 8'h1;
                            ov    = (low_q[g] == 8'hFF);
                        end
                    endcase
                end
                if (g == 0 && inc_h0) begin
                    high_d = high_q[g] + 8'h1;
                end
            end
            assign ovf[g] = ov;
            always_ff @(posedge I_CLK_SYS) begin
                if (I_RESET) begin
                    low_q[g]  <= RESET_BYTE;
                    high_q[g] <= RESET_BYTE;
                end else if (i_CE) begin
                    low_q[g]  <= wl ? i_WDATA : low_d;
                    high_q[g] <= wh ? i_WDATA : high_d;
                end
            end
        end
    endgenerate
    assign h0_ovf = inc_h0 & (high_q[0] == 8'hFF);
    assign c0_low_q  = low_q[0];
    assign c0_high_q = high_q[0];
    assign c1_low_q  = low_q[1];
    assign c1_high_q = high_q[1];

    // External interrupt detection: falling edge or low level on the pin.
    logic [1:0] ext_set;
    assign ext_set[0] = timer_control_q[BIT_TYPE0] ? fall[2] : ~s2_q[2];
    assign ext_set[1] = timer_control_q[BIT_TYPE1] ? fall[3] : ~s2_q[3];

    // Control register; a hardware set outranks software and acknowledges.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            timer_control_q <= RESET_BYTE;
        end else if (i_CE) begin
            if (wr_ctl) begin
                timer_control_q <= i_WDATA;
            end
            if (i_ACK_C1) timer_control_q[BIT_OVF_C1] <= 1'b0;
            if (i_ACK_C0) timer_control_q[BIT_OVF_C0] <= 1'b0;
            if (i_ACK_EXT1 & timer_control_q[BIT_TYPE1]) timer_control_q[BIT_EXT1] <= 1'b0;
            if (i_ACK_EXT0 & timer_control_q[BIT_TYPE0]) timer_control_q[BIT_EXT0] <= 1'b0;
            if (ovf[1] | h0_ovf) timer_control_q[BIT_OVF_C1] <= 1'b1;
            if (ovf[0]) timer_control_q[BIT_OVF_C0] <= 1'b1;
            if (ext_set[1]) timer_control_q[BIT_EXT1] <= 1'b1;
            if (ext_set[0]) timer_control_q[BIT_EXT0] <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            timer_mode_q <= RESET_BYTE;
        end else if (wr_mod) begin
            timer_mode_q <= i_WDATA;
        end
    end

    // Counter 2.
    logic c2_run, c2_cko, c2_inc, c2_up, c2_wrap;
    logic [15:0] c2_next;
    assign c2_run = c2_ctrl_q[BIT_RUN_C2];
    assign c2_cko = c2_mode_q[BIT_CKO_EN] & ~c2_ctrl_q[BIT_SRC_C2];
    // Clock-out counts at clock/2 so each half period is 2 times (65536 minus reload) clocks.
    assign c2_inc = c2_run & (c2_cko ? cko_div_q :
                    (c2_ctrl_q[BIT_SRC_C2] ? fall[4] : per_tick));
    assign c2_up  = ~c2_mode_q[BIT_DOWN_COUNT_ENABLE] | c2_cko | s2_q[5];
    always_comb begin
        c2_next = c2_count_q + 16'h1;
        c2_wrap = 1'b0;
        if (c2_up) begin
            if (c2_count_q == COUNT_MAX) begin
                c2_next = c2_reload_q;
                c2_wrap = 1'b1;
            end
        end else if (c2_count_q == c2_reload_q) begin
            c2_next = COUNT_MAX;
            c2_wrap = 1'b1;
        end else begin
            c2_next = c2_count_q - 16'h1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            cko_div_q <= 1'b0;
        end else if (i_CE) begin
            cko_div_q <= c2_cko & c2_run & ~cko_div_q;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            c2_count_q  <= 16'h0000;
            c2_reload_q <= 16'h0000;
            c2_ctrl_q   <= RESET_BYTE;
            c2_mode_q   <= RESET_BYTE;
            cko_q       <= 1'b0;
        end else if (i_CE) begin
            if (wr_c2m) c2_mode_q <= i_WDATA & 8'h03;
            if (wr_rl) c2_reload_q[7:0]  <= i_WDATA;
            if (wr_rh) c2_reload_q[15:8] <= i_WDATA;
            if (c2_inc) c2_count_q <= c2_next;
            if (wr_l2) c2_count_q[7:0]  <= i_WDATA;
            if (wr_h2) c2_count_q[15:8] <= i_WDATA;
            if (wr_c2c) c2_ctrl_q <= i_WDATA;
            if (c2_inc & c2_wrap) begin
                if (c2_cko) begin
                    cko_q <= ~cko_q;
                end else begin
                    c2_ctrl_q[BIT_OVF_C2] <= 1'b1;
                    if (c2_mode_q[BIT_DOWN_COUNT_ENABLE]) begin
                        c2_ctrl_q[BIT_EXTF_C2] <= ~c2_ctrl_q[BIT_EXTF_C2];
                    end
                end
            end
        end
    end

    // Read port and registered outputs.
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            o_RDATA <= 8'h00;
        end else if (i_CE) begin
            if (i_RD) begin
                case (i_ADDR)
                    ADDR_CONTROL:  o_RDATA <= timer_control_q;
                    ADDR_MODE:     o_RDATA <= timer_mode_q;
                    ADDR_C0_LOW:   o_RDATA <= c0_low_q;
                    ADDR_C0_HIGH:  o_RDATA <= c0_high_q;
                    ADDR_C1_LOW:   o_RDATA <= c1_low_q;
                    ADDR_C1_HIGH:  o_RDATA <= c1_high_q;
                    ADDR_C2_CTRL:  o_RDATA <= c2_ctrl_q;
                    ADDR_C2_MODE:  o_RDATA <= c2_mode_q;
                    ADDR_C2_RLOW:  o_RDATA <= c2_reload_q[7:0];
                    ADDR_C2_RHIGH: o_RDATA <= c2_reload_q[15:8];
                    ADDR_C2_LOW:   o_RDATA <= c2_count_q[7:0];
                    ADDR_C2_HIGH:  o_RDATA <= c2_count_q[15:8];
                    default:       o_RDATA <= 8'h00;
                endcase
            end else begin
                o_RDATA <= 8'h00;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            o_OVF_FLAG_C0           <= 1'b0;
            o_OVF_FLAG_C1           <= 1'b0;
            o_EXT_IRQ_FLAG_0        <= 1'b0;
            o_EXT_IRQ_FLAG_1        <= 1'b0;
            o_OVF_FLAG_C2           <= 1'b0;
            o_COUNTER2_EXT_PIN      <= 1'b0;
            o_COUNTER2_EXT_PIN_OE_N <= 1'b1;
        end else if (i_CE) begin
            o_OVF_FLAG_C0           <= timer_control_q[BIT_OVF_C0];
            o_OVF_FLAG_C1           <= timer_control_q[BIT_OVF_C1];
            o_EXT_IRQ_FLAG_0        <= timer_control_q[BIT_EXT0];
            o_EXT_IRQ_FLAG_1        <= timer_control_q[BIT_EXT1];
            o_OVF_FLAG_C2           <= c2_ctrl_q[BIT_OVF_C2];
            o_COUNTER2_EXT_PIN      <= cko_q;
            o_COUNTER2_EXT_PIN_OE_N <= ~c2_cko;
        end
    end
endmodule

// ===== verif/tcu_port_checker_assertions.sv
/*
 Port checker for the three counter timer unit, bound to each instance.
 Assumes registered flag copies and read data that stand one cycle only.
*/
`timescale 1ns/1ps
module tcu_port_checker (
    // Clock and reset
    input wire logic       I_CLK_SYS,
    input wire logic       I_RESET,
    // Observed ports
    input wire logic       i_WR,
    input wire logic       i_RD,
    input wire logic [7:0] o_RDATA,
    input wire logic       i_ACK_C0,
    input wire logic       i_EXT_IRQ_PIN_0,
    input wire logic       o_COUNTER2_EXT_PIN,
    input wire logic       o_COUNTER2_EXT_PIN_OE_N,
    input wire logic       o_OVF_FLAG_C0,
    input wire logic       o_OVF_FLAG_C1,
    input wire logic       o_EXT_IRQ_FLAG_0,
    input wire logic       o_EXT_IRQ_FLAG_1,
    input wire logic       o_OVF_FLAG_C2
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);
    // Ages saturate so a long quiet spell never wraps back into a window.
    logic [4:0] wr_age_q;
    logic [4:0] ack_age_q;
    logic [4:0] low_age_q;
    always_ff @(posedge I_CLK_SYS) begin
        wr_age_q  <= (I_RESET || i_WR) ? 5'h00 : wr_age_q + {4'h0, ~&wr_age_q};
        ack_age_q <= (I_RESET || i_ACK_C0) ? 5'h00 : ack_age_q + {4'h0, ~&ack_age_q};
        low_age_q <= (I_RESET || !i_EXT_IRQ_PIN_0) ? 5'h00 : low_age_q + {4'h0, ~&low_age_q};
    end
    sequence s_cko_edge;
        !o_COUNTER2_EXT_PIN_OE_N && $changed(o_COUNTER2_EXT_PIN);
    endsequence
    AST_RESET_OUTS: assert property ($fell(I_RESET) |-> o_RDATA == 8'h00
        && o_COUNTER2_EXT_PIN_OE_N && !(o_OVF_FLAG_C0 || o_OVF_FLAG_C1 || o_OVF_FLAG_C2
        || o_EXT_IRQ_FLAG_0 || o_EXT_IRQ_FLAG_1)) else $error("outputs not reset");
    AST_RDATA_IDLE: assert property (!$past(i_RD) |-> o_RDATA == 8'h00)
        else $error("read data outside its cycle");
    AST_NO_CKO_IRQ: assert property ($rose(o_OVF_FLAG_C2) |-> wr_age_q < 5'h04
        || $past(o_COUNTER2_EXT_PIN_OE_N) || $past(o_COUNTER2_EXT_PIN_OE_N, 2)
        || $past(o_COUNTER2_EXT_PIN_OE_N, 3)) else $error("clock-out overflow raised flag");
    AST_CKO_HALF: assert property (s_cko_edge ##1 !o_COUNTER2_EXT_PIN_OE_N
        |-> $stable(o_COUNTER2_EXT_PIN)) else $error("clock-out half period too short");
    AST_OE_BY_WRITE: assert property ($changed(o_COUNTER2_EXT_PIN_OE_N)
        |-> wr_age_q < 5'h04) else $error("pin enable moved without a write");
    AST_EXT0_CAUSE: assert property ($rose(o_EXT_IRQ_FLAG_0)
        |-> low_age_q < 5'h10 || wr_age_q < 5'h04) else $error("ext flag without low pin");
    AST_C0_FALL: assert property ($fell(o_OVF_FLAG_C0)
        |-> ack_age_q < 5'h04 || wr_age_q < 5'h04) else $error("flag cleared without cause");
    AST_C2_FALL: assert property ($fell(o_OVF_FLAG_C2) |-> wr_age_q < 5'h04)
        else $error("counter 2 flag cleared without write");
endmodule

bind three_timer_counter_unit tcu_port_checker u_chk (.I_CLK_SYS(I_CLK_SYS),
    .I_RESET(I_RESET), .i_WR(i_WR), .i_RD(i_RD), .o_RDATA(o_RDATA), .i_ACK_C0(i_ACK_C0),
    .i_EXT_IRQ_PIN_0(i_EXT_IRQ_PIN_0), .o_COUNTER2_EXT_PIN(o_COUNTER2_EXT_PIN),
    .o_COUNTER2_EXT_PIN_OE_N(o_COUNTER2_EXT_PIN_OE_N), .o_OVF_FLAG_C0(o_OVF_FLAG_C0),
    .o_OVF_FLAG_C1(o_OVF_FLAG_C1), .o_EXT_IRQ_FLAG_0(o_EXT_IRQ_FLAG_0),
    .o_EXT_IRQ_FLAG_1(o_EXT_IRQ_FLAG_1), .o_OVF_FLAG_C2(o_OVF_FLAG_C2));

// ===== verif/tcu_pin_model.sv
/*
 Board-side pin model: count pulses and interrupt pin levels.
 Assumes the bench asks for one pulse at a time and waits it out.
*/
`timescale 1ns/1ps
module tcu_pin_model (
    // Clock and commands
    input  wire logic       i_clk,
    input  wire logic       i_pulse,
    input  wire logic [1:0] i_irq_low,
    // Pins
    output logic      [1:0] o_cnt_pin,
    output logic      [1:0] o_irq_pin
);
    logic [4:0] phase_q = 5'h00;
    logic [1:0] irq_q = 2'h3;
    // Each level lasts two peripheral cycles so no sample can miss it.
    always_ff @(posedge i_clk) begin
        phase_q <= (i_pulse && phase_q == 5'h00) ? 5'h18 : phase_q - {4'h0, |phase_q};
    end
    always_ff @(posedge i_clk) begin
        irq_q <= ~i_irq_low;
    end
    // Count pins idle high through their pull-ups.
    assign o_cnt_pin = {1'b1, !(phase_q > 5'h0C)};
    assign o_irq_pin = irq_q;
endmodule

// ===== verif/test_three_timer_counter_unit.sv
/*
 Self-checking bench for the three counter timer unit.
 Assumes the pin model beside it and the checker bound into the design.
*/
`timescale 1ns/1ps
module test_three_timer_counter_unit;
    import tcu_pkg::*;
    logic       sys_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic       wr = 1'b0, rd = 1'b0, dir = 1'b1, pulse = 1'b0, oe_n, cko;
    logic [2:0] acks = 3'h0;
    logic [1:0] irq_low = 2'h0;
    wire logic [1:0] cnt_pin, irq_pin;
    wire logic [4:0] flags;
    int         miscompares = 0, checks_done = 0, n;
    always #5 sys_clk = ~sys_clk;
    tcu_pin_model u_pins (.i_clk(sys_clk), .i_pulse(pulse), .i_irq_low(irq_low),
        .o_cnt_pin(cnt_pin), .o_irq_pin(irq_pin));
    three_timer_counter_unit u_dut (.I_CLK_SYS(sys_clk), .I_RESET(sys_rst), .i_CE(1'b1),
        .i_ADDR(addr), .i_WDATA(wdata), .i_WR(wr), .i_RD(rd), .o_RDATA(rdata),
        .i_ACK_C0(acks[0]), .i_ACK_C1(acks[1]), .i_ACK_EXT0(acks[2]), .i_ACK_EXT1(1'b0),
        .i_COUNTER0_EXT_PIN(cnt_pin[0]), .i_COUNTER1_EXT_PIN(cnt_pin[1]),
        .i_EXT_IRQ_PIN_0(irq_pin[0]), .i_EXT_IRQ_PIN_1(irq_pin[1]),
        .i_COUNTER2_EXT_PIN(oe_n ? 1'b1 : cko), .i_DIRECTION_INPUT_PIN(dir),
        .o_COUNTER2_EXT_PIN(cko), .o_COUNTER2_EXT_PIN_OE_N(oe_n),
        .o_OVF_FLAG_C0(flags[0]), .o_OVF_FLAG_C1(flags[1]), .o_EXT_IRQ_FLAG_0(flags[2]),
        .o_EXT_IRQ_FLAG_1(flags[3]), .o_OVF_FLAG_C2(flags[4]));
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task settle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    task reg_chk(input logic [7:0] a, input logic [7:0] e, input string what);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
        chk(what, {8'h00, e}, {8'h00, d});
    endtask
    task ack(input int k);
        @(posedge sys_clk);
        acks[k] <= 1'b1;
        @(posedge sys_clk);
        acks[k] <= 1'b0;
        settle(3);
    endtask
    // Every wait is bounded; running out ends the run as a failure.
    task wait_sig(input int k, input int lim);
        n = 0;
        while ((k < 5 ? flags[k] !== 1'b1 : cko === d[0]) && n < lim) begin
            settle(1);
            n++;
        end
        if (n == lim) begin
            miscompares++;
            $display("unexpected timeout on %0d expected event seen none", k);
            give_verdict();
        end
    endtask
    task t_regs;
        logic [7:0] a [6] = '{ADDR_CONTROL, ADDR_MODE, ADDR_C0_LOW, ADDR_C1_LOW,
            ADDR_C0_HIGH, ADDR_C1_HIGH};
        chk("pin enable after reset", 16'h1, {15'h0, oe_n});
        foreach (a[i]) reg_chk(a[i], RESET_BYTE, "reset value");
        reg_chk(8'h80, 8'h00, "unmapped read");
        for (int i = 1; i < 6; i++) begin
            reg_wr(a[i], 8'hA5 ^ 8'(i));
            reg_chk(a[i], 8'hA5 ^ 8'(i), "read back");
        end
        reg_wr(ADDR_MODE, {6'h0, MODE_16BIT});
        reg_wr(ADDR_C0_LOW, 8'hFE);
        reg_wr(ADDR_C0_HIGH, 8'hFF);
        reg_wr(ADDR_CONTROL, 8'h10);
        settle(5);
        chk("overflow before two ticks", 16'h0, {15'h0, flags[0]});
        wait_sig(0, 20);
        reg_wr(ADDR_CONTROL, 8'h20);
        reg_chk(ADDR_C0_HIGH, 8'h00, "high byte after rollover");
        reg_chk(ADDR_C0_LOW, 8'h00, "low byte after stop");
        settle(20);
        reg_chk(ADDR_C0_LOW, 8'h00, "stopped count");
        ack(0);
        chk("flag after vector", 16'h0, {15'h0, flags[0]});
    endtask
    task t_reload;
        reg_wr(ADDR_MODE, {2'h0, MODE_RELOAD, 4'h0});
        reg_wr(ADDR_C1_HIGH, 8'hF0);
        reg_wr(ADDR_C1_LOW, 8'hFE);
        reg_wr(ADDR_CONTROL, 8'h40);
        wait_sig(1, 20);
        reg_wr(ADDR_CONTROL, 8'h80);
        reg_chk(ADDR_C1_HIGH, 8'hF0, "reload source kept");
        reg_chk(ADDR_C1_LOW, 8'hF0, "low byte reloaded");
        ack(1);
        chk("flag after vector", 16'h0, {15'h0, flags[1]});
        reg_wr(ADDR_MODE, {2'h0, MODE_13BIT, 2'h0, MODE_13BIT});
        reg_wr(ADDR_C0_LOW, 8'h1F);
        reg_wr(ADDR_C0_HIGH, 8'h05);
        reg_wr(ADDR_CONTROL, 8'h10);
        settle(14);
        reg_wr(ADDR_CONTROL, 8'h00);
        reg_chk(ADDR_C0_HIGH, 8'h06, "prescaler carry");
    endtask
    task t_pins;
        reg_wr(ADDR_MODE, {5'h0, 1'b1, MODE_16BIT});
        reg_wr(ADDR_C0_LOW, 8'h00);
        reg_wr(ADDR_CONTROL, 8'h10);
        repeat (3) begin
            @(posedge sys_clk);
            pulse <= 1'b1;
            @(posedge sys_clk);
            pulse <= 1'b0;
            settle(26);
        end
        reg_chk(ADDR_C0_LOW, 8'h03, "pin edges counted");
        // Close the gate before it is armed so no tick slips in between.
        @(posedge sys_clk);
        irq_low <= 2'h1;
        reg_wr(ADDR_MODE, {4'h0, 1'b1, 1'b0, MODE_16BIT});
        reg_wr(ADDR_C0_LOW, 8'h00);
        settle(30);
        reg_chk(ADDR_C0_LOW, 8'h00, "closed gate");
        chk("level flag", 16'h1, {15'h0, flags[2]});
        @(posedge sys_clk);
        irq_low <= 2'h0;
        // The gate opens three edges later; the next 24 edges hold exactly four ticks.
        settle(27);
        reg_chk(ADDR_C0_LOW, 8'h04, "open gate count");
        reg_wr(ADDR_CONTROL, 8'h01);
        settle(3);
        chk("flag cleared by write", 16'h0, {15'h0, flags[2]});
        @(posedge sys_clk);
        irq_low <= 2'h1;
        wait_sig(2, 20);
        @(posedge sys_clk);
        irq_low <= 2'h0;
        ack(2);
        chk("edge flag after ack", 16'h0, {15'h0, flags[2]});
    endtask
    task t_third;
        reg_wr(ADDR_C2_MODE, 8'h01);
        reg_wr(ADDR_C2_RLOW, 8'h34);
        reg_wr(ADDR_C2_RHIGH, 8'h12);
        reg_wr(ADDR_C2_LOW, 8'hFE);
        reg_wr(ADDR_C2_HIGH, 8'hFF);
        reg_wr(ADDR_C2_CTRL, 8'h04);
        wait_sig(4, 30);
        reg_chk(ADDR_C2_CTRL, 8'hC4, "overflow and toggle");
        reg_chk(ADDR_C2_HIGH, 8'h12, "reload on overflow");
        reg_wr(ADDR_C2_CTRL, 8'h00);
        dir <= 1'b0;
        reg_wr(ADDR_C2_LOW, 8'h36);
        reg_wr(ADDR_C2_CTRL, 8'h04);
        wait_sig(4, 40);
        reg_chk(ADDR_C2_HIGH, 8'hFF, "load on underflow");
        reg_chk(ADDR_C2_CTRL, 8'hC4, "underflow and toggle");
        reg_wr(ADDR_C2_CTRL, 8'h00);
        reg_wr(ADDR_C2_MODE, 8'h02);
        reg_wr(ADDR_C2_RLOW, 8'hFC);
        reg_wr(ADDR_C2_RHIGH, 8'hFF);
        reg_wr(ADDR_C2_LOW, 8'hFC);
        reg_wr(ADDR_C2_HIGH, 8'hFF);
        reg_wr(ADDR_C2_CTRL, 8'h04);
        settle(2);
        chk("clock pin driven", 16'h0, {15'h0, oe_n});
        for (int h = 0; h < 3; h++) begin
            d[0] = cko;
            wait_sig(5, 40);
            if (h > 0)
                chk("half period", 16'(2 * (65536 - 'hFFFC)), 16'(n));
        end
        chk("no overflow interrupt", 16'h0, {15'h0, flags[4]});
        reg_wr(ADDR_C2_MODE, 8'h00);
        settle(3);
        chk("clock pin released", 16'h1, {15'h0, oe_n});
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_reload();
        t_pins();
        t_third();
        give_verdict();
    end
endmodule
